// ==== rtl/ddrr_pkg.sv ====
/*
 * Shared constants for the rank and interface-clock configuration block:
 * widths, configuration word layout, timing counts and state types.
 * Assumes a 25 MHz core clock and a 40-bit serial configuration word.
 */
// Function
// - Data moves twice per link clock (LCLK) period; no single-rate mode.
// - Data path is 64 bits wide; at most four ranks are addressed.
// - No parity or check bits; no ECC; no registered modules expected.
// - Device densities 64 to 512 Mbit, each in x8 or x16 width.
// - Interface frequency setting is loaded at boot from the serial ROM.
// - Interface clock is core clock divided by a ratio from 2 to 15.
// - A core frequency change recomputes and applies a new interface ratio.
// - One shared set of memory-type parameters serves all four ranks.
// - Memory is one contiguous space filled rank after rank.
// - Ranks beyond the first empty rank are never mapped.
// - Each rank has its own active-low select; rank n uses select n.
package ddrr_pkg;
    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int ADDR_W = 30;
    localparam int DATA_W = 64;
    localparam int NRANK = 4;
    localparam int OP_W = 3;
    localparam int RATIO_W = 4;
    localparam logic [3:0] RATIO_MIN = 4'h2;
    localparam logic [3:0] RATIO_MAX = 4'hF;
    localparam logic [3:0] RATIO_BOOT = 4'hF;
    // -------------------------------------------------------------------
    // Configuration word layout, shifted in most significant bit first
    // -------------------------------------------------------------------
    localparam int ROM_BITS = 40;
    localparam int CFG_PRESENT_LSB = 36;
    localparam int CFG_DENS_LSB = 34;
    localparam int CFG_X8_BIT = 33;
    localparam int CFG_RATIO_LSB = 0;
    localparam logic [4:0] RANK0_SHIFT = 5'h19;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CFG_HALF_NS = 160;
    localparam int CFG_HALF_CYC =
        (CFG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        DDRR_D64, DDRR_D128, DDRR_D256, DDRR_D512
    } ddrr_dens_t;
    typedef enum {B_SHIFT, B_DONE} ddrr_boot_t;
    typedef enum {L_IDLE, L_DRIVE, L_CAP} ddrr_link_t;
endpackage

// ==== rtl/ddrr_clkdiv.sv ====
/*
 * Interface clock divider on the core clock.
 * Assumes the ratio input is already clamped to the legal range.
 */
`timescale 1ns/10ps
module ddrr_clkdiv
    import ddrr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [RATIO_W-1:0] ratio,
    output logic ck
);
    logic [RATIO_W-1:0] cnt_q;
    logic [RATIO_W-1:0] cur_q;
    logic wrap;
    logic ck_d;
    logic ck_q;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // New ratio only taken at a period boundary to avoid runt pulses
    assign wrap = (cnt_q == cur_q - 4'h1);
    assign ck_d = (wrap ? 4'h0 : cnt_q + 4'h1) < (cur_q >> 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            cur_q <= RATIO_BOOT;
            ck_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 4'h0 : cnt_q + 4'h1;
            cur_q <= wrap ? ratio : cur_q;
            ck_q <= ck_d;
        end
    end

    assign ck = ck_q;
endmodule

// ==== rtl/ddrr_dq_io.sv ====
/*
 * Double-rate data pins: one beat on each edge of the link clock.
 * Assumes the caller holds wdata stable while drive is high.
 */
`timescale 1ns/10ps
module ddrr_dq_io
    import ddrr_pkg::*;
(
    input wire logic lclk,
    input wire logic lrst_n,
    input wire logic drive,
    input wire logic [2*DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_n,
    output logic [2*DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] rise_q;
    logic [DATA_W-1:0] fall_q;
    logic [DATA_W-1:0] cap_r_q;
    logic [DATA_W-1:0] cap_f_q;
    logic oe_n_q;

    // ---------------------------------------------------------------
    // Rising-edge beat
    // ---------------------------------------------------------------
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            rise_q <= '0;
            cap_r_q <= '0;
            oe_n_q <= 1'b1;
        end else begin
            rise_q <= wdata[DATA_W-1:0];
            cap_r_q <= dq_i;
            oe_n_q <= !drive;
        end
    end

    // ---------------------------------------------------------------
    // Falling-edge beat
    // ---------------------------------------------------------------
    always_ff @(negedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            fall_q <= '0;
            cap_f_q <= '0;
        end else begin
            fall_q <= wdata[2*DATA_W-1:DATA_W];
            cap_f_q <= dq_i;
        end
    end

    // Pure 64-bit lanes, no check bits alongside
    assign dq_o = lclk ? rise_q : fall_q;
    assign dq_oe_n = oe_n_q;
    assign rdata = {cap_f_q, cap_r_q};
endmodule

// ==== rtl/ddrr_top.sv ====
/*
 * Rank organisation, address decode, boot load of the configuration
 * word and interface-clock ratio, plus the link-side access engine.
 * Assumes a serial ROM streaming the word while CFG_CS is high, and
 * a link clock LCLK unrelated to CLK.
 */
`timescale 1ns/10ps
module ddrr_top
    import ddrr_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic LCLK,
    input wire logic [OP_W-1:0] CORE_OP,
    output logic CFG_CS,
    output logic CFG_SCLK,
    input wire logic CFG_SDATA,
    output logic BOOT_DONE,
    output logic [2:0] MEM_RANKS,
    output logic MEM_CK,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [2*DATA_W-1:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic RSP_ERR,
    output logic [2*DATA_W-1:0] RSP_RDATA,
    output logic RANK_SELECT_0_N,
    output logic RANK_SELECT_1_N,
    output logic RANK_SELECT_2_N,
    output logic RANK_SELECT_3_N,
    input wire logic [DATA_W-1:0] DQ_I,
    output logic [DATA_W-1:0] DQ_O,
    output logic DQ_OE_N
);
    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [3:0] clamp_ratio(input logic [3:0] r);
        clamp_ratio = (r < RATIO_MIN) ? RATIO_MIN : r;
    endfunction

    // Count of ranks filled from rank 0 up to the first hole
    function automatic logic [2:0] lead_ranks(input logic [3:0] p);
        lead_ranks = !p[0] ? 3'h0 : !p[1] ? 3'h1 : !p[2] ? 3'h2 :
                     !p[3] ? 3'h3 : 3'h4;
    endfunction

    // ---------------------------------------------------------------
    // Reset synchronisers
    // ---------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;
    logic lrst_s1_q;
    logic lrst_n;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    always_ff @(posedge LCLK or negedge NRST) begin
        if (!NRST) begin
            lrst_s1_q <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_n <= lrst_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // Serial data input filter
    // ---------------------------------------------------------------
    logic sd_s1_q;
    logic sd_s2_q;
    logic sd_s3_q;
    logic sd_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
            sd_s3_q <= 1'b0;
            sd_q <= 1'b0;
        end else begin
            sd_s1_q <= CFG_SDATA;
            sd_s2_q <= sd_s1_q;
            sd_s3_q <= sd_s2_q;
            sd_q <= (sd_s2_q == sd_s3_q) ? sd_s3_q : sd_q;
        end
    end

    // ---------------------------------------------------------------
    // Boot load of the configuration word
    // ---------------------------------------------------------------
    ddrr_boot_t boot_q;
    ddrr_boot_t boot_d;
    logic [2:0] ph_q;
    logic [5:0] bit_q;
    logic sclk_q;
    logic [ROM_BITS-1:0] rom_q;
    logic ph_end;
    logic sample;
    logic last_bit;

    // Sample at the end of the high phase: the filter adds four cycles
    assign ph_end = (ph_q == 3'(CFG_HALF_CYC - 1));
    assign sample = (boot_q == B_SHIFT) && ph_end && sclk_q;
    assign last_bit = (bit_q == 6'(ROM_BITS - 1));
    assign boot_d = (sample && last_bit) ? B_DONE : boot_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            boot_q <= B_SHIFT;
            ph_q <= 3'h0;
            bit_q <= 6'h00;
            sclk_q <= 1'b0;
            rom_q <= '0;
        end else begin
            boot_q <= boot_d;
            if (boot_q == B_SHIFT) begin
                ph_q <= ph_end ? 3'h0 : ph_q + 3'h1;
                sclk_q <= ph_end ? !sclk_q : sclk_q;
            end else begin
                ph_q <= 3'h0;
                sclk_q <= 1'b0;
            end
            if (sample) begin
                rom_q <= {rom_q[ROM_BITS-2:0], sd_q};
                bit_q <= bit_q + 6'h01;
            end
        end
    end

    assign CFG_CS = (boot_q == B_SHIFT);
    assign CFG_SCLK = sclk_q;
    assign BOOT_DONE = (boot_q == B_DONE);

    // ---------------------------------------------------------------
    // Shared geometry and interface ratio
    // ---------------------------------------------------------------
    // One geometry for every rank, so capacity is a single shift
    logic [3:0] present;
    ddrr_dens_t dens;
    logic x8;
    logic [4:0] rank_shift;
    logic [2:0] nranks;
    logic [3:0] op_ratio;
    logic [3:0] ratio_d;
    logic [3:0] ratio_q;

    assign present = rom_q[CFG_PRESENT_LSB +: 4];
    assign dens = ddrr_dens_t'(rom_q[CFG_DENS_LSB +: 2]);
    assign x8 = rom_q[CFG_X8_BIT];
    assign rank_shift = RANK0_SHIFT + {3'h0, dens} + {4'h0, x8};
    // Unsupported x8 population above two ranks is left to the ROM
    assign nranks = BOOT_DONE ? lead_ranks(present) : 3'h0;
    assign op_ratio = rom_q[CFG_RATIO_LSB + 4*CORE_OP +: 4];
    // Re-evaluated every cycle so a new operating point reaches ratio_q one cycle later
    assign ratio_d = BOOT_DONE ? clamp_ratio(op_ratio) : RATIO_BOOT;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ratio_q <= RATIO_BOOT;
        end else begin
            ratio_q <= ratio_d;
        end
    end

    assign MEM_RANKS = nranks;

    ddrr_clkdiv u_div (
        .clk(CLK),
        .rst_n(rst_n),
        .ratio(ratio_q),
        .ck(MEM_CK)
    );

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] rank_idx;
    logic in_range;
    logic [NRANK-1:0] rank_hot;

    assign rank_idx = REQ_ADDR >> rank_shift;
    assign in_range = (rank_idx < ADDR_W'(nranks));
    assign rank_hot = in_range ? (4'h1 << rank_idx[1:0]) : 4'h0;

    // ---------------------------------------------------------------
    // Core-side request handshake
    // ---------------------------------------------------------------
    logic busy_q;
    logic req_tgl_q;
    logic [NRANK-1:0] rank_q;
    logic wr_q;
    logic [2*DATA_W-1:0] wdata_q;
    logic accept;
    logic ack_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_seen_q;
    logic ack_new;
    logic rsp_q;
    logic err_q;
    logic [2*DATA_W-1:0] rdata_q;
    logic [2*DATA_W-1:0] link_rdata_q;

    assign REQ_READY = BOOT_DONE && !busy_q && !rsp_q;
    assign accept = REQ_VALID && REQ_READY;
    assign ack_new = (ack_s2_q != ack_seen_q);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            req_tgl_q <= 1'b0;
            rank_q <= 4'h0;
            wr_q <= 1'b0;
            wdata_q <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_seen_q <= 1'b0;
            rsp_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_seen_q <= ack_s2_q;
            rsp_q <= 1'b0;
            if (accept && !in_range) begin
                rsp_q <= 1'b1;
                err_q <= 1'b1;
            end else if (accept) begin
                busy_q <= 1'b1;
                req_tgl_q <= !req_tgl_q;
                rank_q <= rank_hot;
                wr_q <= REQ_WRITE;
                wdata_q <= REQ_WDATA;
            end else if (busy_q && ack_new) begin
                busy_q <= 1'b0;
                rsp_q <= 1'b1;
                err_q <= 1'b0;
                rdata_q <= wr_q ? '0 : link_rdata_q;
            end
        end
    end

    assign RSP_VALID = rsp_q;
    assign RSP_ERR = err_q;
    assign RSP_RDATA = rdata_q;

    // ---------------------------------------------------------------
    // Link-side access engine
    // ---------------------------------------------------------------
    // Request fields stay frozen until the ack toggle comes back
    ddrr_link_t lst_q;
    ddrr_link_t lst_d;
    logic rq_s1_q;
    logic rq_s2_q;
    logic rq_seen_q;
    logic [NRANK-1:0] cs_n_q;
    logic [2*DATA_W-1:0] io_rdata;
    logic drive;

    assign lst_d = (lst_q == L_IDLE && rq_s2_q != rq_seen_q) ? L_DRIVE :
                   (lst_q == L_DRIVE) ? L_CAP : L_IDLE;
    assign drive = (lst_q == L_DRIVE) && wr_q;

    always_ff @(posedge LCLK or negedge lrst_n) begin
        if (!lrst_n) begin
            lst_q <= L_IDLE;
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_seen_q <= 1'b0;
            cs_n_q <= 4'hF;
            ack_tgl_q <= 1'b0;
            link_rdata_q <= '0;
        end else begin
            lst_q <= lst_d;
            rq_s1_q <= req_tgl_q;
            rq_s2_q <= rq_s1_q;
            case (lst_q)
                L_IDLE: begin
                    cs_n_q <= 4'hF;
                    if (lst_d == L_DRIVE) begin
                        rq_seen_q <= rq_s2_q;
                        cs_n_q <= ~rank_q;
                    end
                end
                L_DRIVE: begin
                    cs_n_q <= ~rank_q;
                end
                L_CAP: begin
                    cs_n_q <= 4'hF;
                    link_rdata_q <= io_rdata;
                    ack_tgl_q <= !ack_tgl_q;
                end
                default: begin
                    cs_n_q <= 4'hF;
                end
            endcase
        end
    end

    assign RANK_SELECT_0_N = cs_n_q[0];
    assign RANK_SELECT_1_N = cs_n_q[1];
    assign RANK_SELECT_2_N = cs_n_q[2];
    assign RANK_SELECT_3_N = cs_n_q[3];

    ddrr_dq_io u_dq (
        .lclk(LCLK),
        .lrst_n(lrst_n),
        .drive(drive),
        .wdata(wdata_q),
        .dq_i(DQ_I),
        .dq_o(DQ_O),
        .dq_oe_n(DQ_OE_N),
        .rdata(io_rdata)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_cs_onehot;
        @(posedge LCLK) disable iff (!lrst_n)
        $countones(~cs_n_q) <= 1;
    endproperty
    a_cs_onehot: assert property (p_cs_onehot)
        else $error("More than one rank select active");

    property p_boot_ratio;
        @(posedge CLK) disable iff (!rst_n)
        $rose(BOOT_DONE) |=> ratio_q == clamp_ratio(op_ratio);
    endproperty
    a_boot_ratio: assert property (p_boot_ratio)
        else $error("Ratio not loaded from boot word");

    property p_ratio_range;
        @(posedge CLK) disable iff (!rst_n)
        ratio_q >= RATIO_MIN && ratio_q <= RATIO_MAX;
    endproperty
    a_ratio_range: assert property (p_ratio_range)
        else $error("Divider ratio out of range");

    property p_dvfs;
        @(posedge CLK) disable iff (!rst_n)
        BOOT_DONE && $changed(CORE_OP)
            |=> ratio_q == clamp_ratio($past(rom_q[4*CORE_OP +: 4]));
    endproperty
    a_dvfs: assert property (p_dvfs)
        else $error("Ratio did not follow core operating point");

    property p_gap;
        @(posedge CLK) disable iff (!rst_n)
        BOOT_DONE |-> (present & ((4'h1 << nranks) - 4'h1))
            == ((4'h1 << nranks) - 4'h1)
            && (nranks == 3'h4 || !present[nranks[1:0]]);
    endproperty
    a_gap: assert property (p_gap)
        else $error("Rank beyond a hole was mapped");

    property p_oor;
        @(posedge CLK) disable iff (!rst_n)
        accept && (REQ_ADDR >> rank_shift) >= ADDR_W'(nranks)
            |=> RSP_VALID && RSP_ERR && !busy_q;
    endproperty
    a_oor: assert property (p_oor)
        else $error("Out-of-range address not refused");

    property p_rank_hit;
        @(posedge CLK) disable iff (!rst_n)
        accept && in_range
            |=> busy_q && rank_q == (4'h1 << $past(rank_idx[1:0]));
    endproperty
    a_rank_hit: assert property (p_rank_hit)
        else $error("Request steered to wrong rank");

    property p_rsp_bound;
        @(posedge CLK) disable iff (!rst_n)
        $rose(busy_q) |-> ##[1:40] RSP_VALID;
    endproperty
    a_rsp_bound: assert property (p_rsp_bound)
        else $error("Link access did not complete");

    property p_drive;
        @(posedge LCLK) disable iff (!lrst_n)
        lst_q == L_DRIVE && wr_q |=> !DQ_OE_N && cs_n_q == ~rank_q;
    endproperty
    a_drive: assert property (p_drive)
        else $error("Write beats not driven");

    c_write: cover property (@(posedge CLK) disable iff (!rst_n)
        accept && REQ_WRITE && in_range);
    c_read: cover property (@(posedge CLK) disable iff (!rst_n)
        RSP_VALID && !RSP_ERR && !wr_q);
    c_err: cover property (@(posedge CLK) disable iff (!rst_n)
        RSP_VALID && RSP_ERR);
    c_dvfs: cover property (@(posedge CLK) disable iff (!rst_n)
        BOOT_DONE && $changed(ratio_q));
endmodule

// ==== dv/ddrr_far_model.sv ====
/*
 * Far-side model: serial configuration ROM and one data pattern per rank.
 * Assumes the selects and the data enable are registered on LCLK.
 */
`timescale 1ns/10ps
module ddrr_far_model
    import ddrr_pkg::*;
(
    input wire logic [ROM_BITS-1:0] WORD,
    input wire logic NRST,
    input wire logic LCLK,
    input wire logic CFG_CS,
    input wire logic CFG_SCLK,
    output logic CFG_SDATA,
    input wire logic [3:0] SEL_N,
    input wire logic DQ_OE_N,
    output logic [DATA_W-1:0] DQ_I
);
    // ----------------------------------------------------------------
    // Boot ROM, data changes while the serial clock is low
    // ----------------------------------------------------------------
    int idx;
    logic tog;
    logic [1:0] rk;
    always @(negedge CFG_SCLK or negedge NRST) begin
        if (!NRST) begin
            idx <= 0;
        end else if (CFG_CS) begin
            idx <= idx + 1;
        end
    end
    // Ratios keep the link inside its legal band, same for all ranks
    assign CFG_SDATA = CFG_CS ? WORD[ROM_BITS-1-idx] : idx[0];
    // ----------------------------------------------------------------
    // Unbuffered x8 or x16 ranks, identical geometry, one shared setting
    // ----------------------------------------------------------------
    always @(posedge LCLK) begin
        tog <= !tog;
    end
    initial tog = 1'b0;
    assign rk = !SEL_N[1] ? 2'h1 : !SEL_N[2] ? 2'h2 : !SEL_N[3] ? 2'h3 : 2'h0;
    // Released bus shows a toggling pattern, not the last value
    assign DQ_I = (!(&SEL_N) && DQ_OE_N) ? {16'hC0DE, 46'h0, rk}
                                         : {DATA_W{tog}};
endmodule

// ==== dv/ddr_rank_and_clock_config_bench.sv ====
/*
 * Self-checking bench: boot load, rank decode, selects, data beats and
 * interface clock ratio for operating points 0 to 3.
 * Assumes the far-side model file is compiled before it.
 */
`timescale 1ns/10ps
module ddr_rank_and_clock_config_bench
    import ddrr_pkg::*;
;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
        n_errors++; $display("ERROR %0t got %0h exp %0h", $time, a, b); \
    end end
    logic CLK = 0, LCLK = 0, NRST = 0, CFG_CS, CFG_SCLK, CFG_SDATA;
    logic BOOT_DONE, MEM_CK, REQ_VALID = 0, REQ_READY, REQ_WRITE = 0;
    logic RSP_VALID, RSP_ERR, DQ_OE_N;
    logic [OP_W-1:0] CORE_OP = 0;
    logic [2:0] MEM_RANKS;
    logic [ADDR_W-1:0] REQ_ADDR = 0;
    logic [2*DATA_W-1:0] REQ_WDATA = 0, RSP_RDATA, got_w;
    logic [DATA_W-1:0] DQ_I, DQ_O;
    wire [3:0] sel_n;
    logic [3:0] seen = 0;
    logic [ROM_BITS-1:0] word = '0;
    int n_errors = 0, n_compared = 0, cyc = 0, p;
    // ----------------------------------------------------------------
    // Clocks, timeout, link monitors
    // ----------------------------------------------------------------
    initial forever #20 CLK = !CLK;
    initial begin
        #7;
        forever #15 LCLK = !LCLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    always @(posedge LCLK) begin
        seen <= seen | ~sel_n;
        #7;
        if (!DQ_OE_N) got_w[DATA_W-1:0] = DQ_O;
    end
    always @(negedge LCLK) begin
        #7;
        if (!DQ_OE_N) got_w[2*DATA_W-1:DATA_W] = DQ_O;
    end
    ddrr_top dut_u (.CLK(CLK), .NRST(NRST), .LCLK(LCLK), .CORE_OP(CORE_OP),
        .CFG_CS(CFG_CS), .CFG_SCLK(CFG_SCLK), .CFG_SDATA(CFG_SDATA),
        .BOOT_DONE(BOOT_DONE), .MEM_RANKS(MEM_RANKS), .MEM_CK(MEM_CK),
        .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID),
        .RSP_ERR(RSP_ERR), .RSP_RDATA(RSP_RDATA),
        .RANK_SELECT_0_N(sel_n[0]), .RANK_SELECT_1_N(sel_n[1]),
        .RANK_SELECT_2_N(sel_n[2]), .RANK_SELECT_3_N(sel_n[3]),
        .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N));
    ddrr_far_model far_u (.WORD(word), .NRST(NRST), .LCLK(LCLK),
        .CFG_CS(CFG_CS),
        .CFG_SCLK(CFG_SCLK), .CFG_SDATA(CFG_SDATA), .SEL_N(sel_n),
        .DQ_OE_N(DQ_OE_N), .DQ_I(DQ_I));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [2*DATA_W-1:0] d);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= w;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        seen <= 4'h0;
        do @(negedge CLK); while (REQ_READY !== 1'b1);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        for (int k = 0; k < 60 && RSP_VALID !== 1'b1; k++) @(negedge CLK);
        `CHK(RSP_VALID, 1'b1)
    endtask
    // Reset with a new boot word, then wait for the load to finish
    task automatic boot(input logic [ROM_BITS-1:0] w);
        @(posedge CLK);
        NRST <= 1'b0;
        word <= w;
        repeat (3) @(posedge CLK);
        NRST <= 1'b1;
        @(negedge CLK);
        `CHK({REQ_READY, sel_n, DQ_OE_N}, 6'h1F)
        for (int k = 0; k < 1000 && BOOT_DONE !== 1'b1; k++) @(negedge CLK);
        `CHK({BOOT_DONE, CFG_CS, CFG_SCLK}, 3'h4)
    endtask
    task automatic meas(output int per);
        logic pv;
        per = 0;
        pv = 1'b1;
        for (int k = 0; k < 40 && !(MEM_CK && !pv); k++) begin
            pv = MEM_CK;
            @(negedge CLK);
        end
        do begin
            pv = MEM_CK;
            @(negedge CLK);
            per++;
        end while (!(MEM_CK && !pv) && per < 40);
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Rows: address, error, selects seen low, rank of read pattern
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] r_a [6] = '{30'h10, 30'h3FFFFF0, 30'h4000000,
                                    30'h7FFFFF0, 30'h8000000, 30'hC000000};
    logic r_e [6] = '{0, 0, 0, 0, 1, 1};
    logic [3:0] r_s [6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h0, 4'h0};
    logic [3:0] o_p [4] = '{4'h3, 4'h5, 4'h2, 4'hF};
    logic [2*DATA_W-1:0] wd, pat;
    initial begin
        boot(40'hB4_2222_F153);
        `CHK(MEM_RANKS, 3'h2)
        for (int i = 0; i < 6; i++) begin
            wd = {32'hFACE_0000 + i, 32'h1, 32'h2222_0000 + i, 32'h3};
            got_w = '0;
            access(1'b1, r_a[i], wd);
            `CHK(RSP_ERR, r_e[i])
            `CHK(seen, r_s[i])
            if (!r_e[i]) `CHK(got_w, wd)
            access(1'b0, r_a[i], '0);
            pat = {2{16'hC0DE, 46'h0, r_a[i][27:26]}};
            `CHK(RSP_ERR, r_e[i])
            if (!r_e[i]) `CHK(RSP_RDATA, pat)
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            CORE_OP <= i[OP_W-1:0];
            repeat (40) @(negedge CLK);
            meas(p);
            `CHK(p[3:0], o_p[i])
        end
        // Mid-run reset: x8 512 Mbit, two ranks, zero ratios clamp up
        boot(40'h3E_0000_0000);
        `CHK(MEM_RANKS, 3'h2)
        access(1'b0, 30'h3FFFFFF0, '0);
        `CHK({RSP_ERR, seen}, 5'h02)
        `CHK(RSP_RDATA, {2{16'hC0DE, 46'h0, 2'h1}})
        repeat (20) @(negedge CLK);
        meas(p);
        `CHK(p[3:0], RATIO_MIN)
        tally_and_finish();
    end
endmodule
